// file: logic/sra_consts.vh
`ifndef SRA_CONSTS_VH
`define SRA_CONSTS_VH

// clocking and converter rates
`define SRA_SYS_CLK_HZ 10000000
`define SRA_MOD_CLK_HZ 1048576
`define SRA_OSR 256
`define SRA_SAMPLE_RATE (`SRA_MOD_CLK_HZ / `SRA_OSR)
`define SRA_TICK_PERIOD_S 1
`define SRA_PHASE_W 32

// datapath shape
`define SRA_NUM_CH 7
`define SRA_LAST_CH 3'h6
`define SRA_SAMPLE_W 24
`define SRA_ACC_W 64
`define SRA_FRAME_SHIFT 12
`define SRA_ROOT_IN_W 52
`define SRA_ROOT_W 26
`define SRA_ROOT_STEPS 5'h19

// dc tracking filter: 24 integer bits, 16 fraction bits, one guard bit
`define SRA_DC_W 41
`define SRA_DC_FRAC 16
`define SRA_DC_SHIFT 8

// calibration storage
`define SRA_SCALE_W 16
`define SRA_SCALE_FRAC 14
`define SRA_SCALE_RESET 16'h4000
`define SRA_OFFSET_W 32
`define SRA_OFFSET_RESET 32'h00000000
`define SRA_RESULT_W 32

`endif

// file: logic/sra_isqrt.v
`timescale 1ns/1ps
`include "sra_consts.vh"

module sra_isqrt (
  input wire core_clk,
  input wire reset_n,
  input wire start,
  input wire [`SRA_ROOT_IN_W-1:0] radicand,
  output reg [`SRA_ROOT_W-1:0] root_reg,
  output reg done_reg
);

  reg [`SRA_ROOT_IN_W-1:0] num_reg;
  reg [`SRA_ROOT_W+1:0] rem_reg;
  reg [4:0] step_reg;
  reg busy_reg;
  wire [`SRA_ROOT_W+1:0] rem_shift;
  wire [`SRA_ROOT_W+1:0] trial;

  // restoring square root, one result bit per cycle
  assign rem_shift = {rem_reg[`SRA_ROOT_W-1:0], num_reg[`SRA_ROOT_IN_W-1:`SRA_ROOT_IN_W-2]};
  assign trial = {root_reg, 2'h1};

  always @(posedge core_clk) begin
    if (!reset_n) begin
      num_reg <= {`SRA_ROOT_IN_W{1'b0}};
      rem_reg <= {(`SRA_ROOT_W+2){1'b0}};
      root_reg <= {`SRA_ROOT_W{1'b0}};
      step_reg <= 5'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start && !busy_reg) begin
        num_reg <= radicand;
        rem_reg <= {(`SRA_ROOT_W+2){1'b0}};
        root_reg <= {`SRA_ROOT_W{1'b0}};
        step_reg <= 5'h00;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        num_reg <= {num_reg[`SRA_ROOT_IN_W-3:0], 2'h0};
        if (rem_shift >= trial) begin
          rem_reg <= rem_shift - trial;
          root_reg <= {root_reg[`SRA_ROOT_W-2:0], 1'b1};
        end else begin
          rem_reg <= rem_shift;
          root_reg <= {root_reg[`SRA_ROOT_W-2:0], 1'b0};
        end
        step_reg <= step_reg + 5'h01;
        if (step_reg == `SRA_ROOT_STEPS) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

endmodule // sra_isqrt

// file: logic/sra_rms_accum.v
`timescale 1ns/1ps
`include "sra_consts.vh"

module sra_rms_accum #(
  parameter SYS_CLK_HZ = `SRA_SYS_CLK_HZ,
  parameter TICK_CYCLES = `SRA_SYS_CLK_HZ * `SRA_TICK_PERIOD_S,
  parameter FRAME_SHIFT = `SRA_FRAME_SHIFT
) (
  input wire core_clk,
  input wire reset_n,
  input wire sample_ready,
  input wire [`SRA_NUM_CH*`SRA_SAMPLE_W-1:0] sample_data,
  input wire frame_ack,
  input wire cfg_write,
  input wire [2:0] cfg_channel,
  input wire [`SRA_SCALE_W-1:0] cfg_scale,
  input wire [`SRA_OFFSET_W-1:0] cfg_offset,
  output reg modulator_clock,
  output reg second_tick,
  output reg frame_ready,
  output reg rms_valid,
  output wire [`SRA_NUM_CH*`SRA_RESULT_W-1:0] current_rms_result
);

  localparam [1:0] A_IDLE = 2'h0;
  localparam [1:0] A_PROC = 2'h1;
  localparam [1:0] A_SWAP = 2'h2;
  localparam [1:0] C_IDLE = 2'h0;
  localparam [1:0] C_START = 2'h1;
  localparam [1:0] C_WAIT = 2'h2;
  localparam [63:0] PH_INC_FULL = (64'd1 << `SRA_PHASE_W) * `SRA_MOD_CLK_HZ / SYS_CLK_HZ;
  localparam [`SRA_PHASE_W-1:0] PH_INC = PH_INC_FULL[`SRA_PHASE_W-1:0];
  localparam [12:0] FRAME_LAST = (13'h0001 << FRAME_SHIFT) - 13'h0001;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  reg [`SRA_PHASE_W-1:0] phase_reg;
  reg [31:0] tick_cnt_reg;
  reg [1:0] acq_state_reg;
  reg [2:0] ch_reg;
  reg [12:0] frame_cnt_reg;
  reg work_bank_reg;
  reg [`SRA_NUM_CH*`SRA_SAMPLE_W-1:0] sample_lat_reg;
  reg [1:0] calc_state_reg;
  reg [2:0] calc_ch_reg;
  reg [`SRA_DC_W-1:0] dc_reg [0:`SRA_NUM_CH-1];
  reg [`SRA_SCALE_W-1:0] scale_reg [0:`SRA_NUM_CH-1];
  reg [`SRA_OFFSET_W-1:0] offset_reg [0:`SRA_NUM_CH-1];
  reg [`SRA_RESULT_W-1:0] rms_reg [0:`SRA_NUM_CH-1];
  reg [`SRA_ACC_W-1:0] acc_reg [0:2*`SRA_NUM_CH-1];

  wire signed [`SRA_SAMPLE_W-1:0] cur_sample;
  wire signed [`SRA_SAMPLE_W-1:0] dc_int;
  wire signed [`SRA_SAMPLE_W:0] corr;
  wire signed [2*`SRA_SAMPLE_W+1:0] square;
  wire signed [`SRA_DC_W-1:0] dc_step;
  wire [3:0] held_idx;
  wire [`SRA_ACC_W-1:0] held_mean;
  wire [`SRA_ROOT_W-1:0] root;
  wire root_done;
  wire [`SRA_ROOT_W+`SRA_SCALE_W-1:0] scaled_full;
  wire [`SRA_RESULT_W-1:0] scaled;
  wire frame_end;

  // channel selection out of the latched sample set
  assign cur_sample = sample_lat_reg[ch_reg*`SRA_SAMPLE_W +: `SRA_SAMPLE_W];
  assign dc_int = dc_reg[ch_reg][`SRA_DC_FRAC+`SRA_SAMPLE_W-1:`SRA_DC_FRAC];
  assign corr = {cur_sample[`SRA_SAMPLE_W-1], cur_sample} - {dc_int[`SRA_SAMPLE_W-1], dc_int};
  assign square = corr * corr;
  assign dc_step = $signed({corr, {`SRA_DC_FRAC{1'b0}}}) >>> `SRA_DC_SHIFT;
  assign frame_end = (acq_state_reg == A_PROC) && (ch_reg == `SRA_LAST_CH) && (frame_cnt_reg == FRAME_LAST);

  // fractional divider for the converter modulator clock
  always @(posedge core_clk) begin
    if (!reset_n) begin
      phase_reg <= {`SRA_PHASE_W{1'b0}};
      modulator_clock <= 1'b0;
    end else begin
      phase_reg <= phase_reg + PH_INC;
      modulator_clock <= phase_reg[`SRA_PHASE_W-1];
    end
  end

  // once-per-second timekeeping tick
  always @(posedge core_clk) begin
    if (!reset_n) begin
      tick_cnt_reg <= 32'h00000000;
      second_tick <= 1'b0;
    end else begin
      second_tick <= 1'b0;
      if (tick_cnt_reg == TICK_LAST) begin
        tick_cnt_reg <= 32'h00000000;
        second_tick <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      end
    end
  end

  // acquisition sequencer
  always @(posedge core_clk) begin
    if (!reset_n) begin
      acq_state_reg <= A_IDLE;
      ch_reg <= 3'h0;
      frame_cnt_reg <= 13'h0000;
      work_bank_reg <= 1'b0;
      sample_lat_reg <= {(`SRA_NUM_CH*`SRA_SAMPLE_W){1'b0}};
    end else begin
      case (acq_state_reg)
        A_IDLE: begin
          if (sample_ready) begin
            sample_lat_reg <= sample_data;
            ch_reg <= 3'h0;
            acq_state_reg <= A_PROC;
          end
        end
        A_PROC: begin
          if (ch_reg == `SRA_LAST_CH) begin
            if (frame_end) begin
              frame_cnt_reg <= 13'h0000;
              acq_state_reg <= A_SWAP;
            end else begin
              frame_cnt_reg <= frame_cnt_reg + 13'h0001;
              acq_state_reg <= A_IDLE;
            end
          end else begin
            ch_reg <= ch_reg + 3'h1;
          end
        end
        A_SWAP: begin
          work_bank_reg <= ~work_bank_reg;
          acq_state_reg <= A_IDLE;
        end
        default: begin
          acq_state_reg <= A_IDLE;
        end
      endcase
    end
  end

  // frame-available flag, a new frame beats a same-cycle acknowledge
  always @(posedge core_clk) begin
    if (!reset_n) begin
      frame_ready <= 1'b0;
    end else if (acq_state_reg == A_SWAP) begin
      frame_ready <= 1'b1;
    end else if (frame_ack) begin
      frame_ready <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SRA_NUM_CH; gi = gi + 1) begin : g_ch
      always @(posedge core_clk) begin
        if (!reset_n) begin
          dc_reg[gi] <= {`SRA_DC_W{1'b0}};
          scale_reg[gi] <= `SRA_SCALE_RESET;
          offset_reg[gi] <= `SRA_OFFSET_RESET;
        end else begin
          if (acq_state_reg == A_PROC && ch_reg == gi) begin
            dc_reg[gi] <= dc_reg[gi] + dc_step;
          end
          if (cfg_write && cfg_channel == gi) begin
            scale_reg[gi] <= cfg_scale;
            offset_reg[gi] <= cfg_offset;
          end
        end
      end
      assign current_rms_result[gi*`SRA_RESULT_W +: `SRA_RESULT_W] = rms_reg[gi];
    end
    for (gi = 0; gi < 2*`SRA_NUM_CH; gi = gi + 1) begin : g_acc
      always @(posedge core_clk) begin
        if (!reset_n) begin
          acc_reg[gi] <= {`SRA_ACC_W{1'b0}};
        end else if (acq_state_reg == A_SWAP && work_bank_reg != (gi / `SRA_NUM_CH)) begin
          acc_reg[gi] <= {`SRA_ACC_W{1'b0}};
        end else if (acq_state_reg == A_PROC && ch_reg == (gi % `SRA_NUM_CH)
                     && work_bank_reg == (gi / `SRA_NUM_CH)) begin
          acc_reg[gi] <= acc_reg[gi] + {{(`SRA_ACC_W-2*`SRA_SAMPLE_W-2){1'b0}}, square};
        end
      end
    end
  endgenerate

  // result stage reads only the held set
  assign held_idx = work_bank_reg ? {1'b0, calc_ch_reg} : ({1'b0, calc_ch_reg} + 4'h7);
  assign held_mean = acc_reg[held_idx] >> FRAME_SHIFT;
  assign scaled_full = root * scale_reg[calc_ch_reg];
  assign scaled = {{(`SRA_RESULT_W-`SRA_ROOT_W-`SRA_SCALE_W+`SRA_SCALE_FRAC){1'b0}},
                   scaled_full[`SRA_ROOT_W+`SRA_SCALE_W-1:`SRA_SCALE_FRAC]};

  sra_isqrt u_isqrt (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(calc_state_reg == C_START),
    .radicand(held_mean[`SRA_ROOT_IN_W-1:0]),
    .root_reg(root),
    .done_reg(root_done)
  );

  integer k;
  always @(posedge core_clk) begin
    if (!reset_n) begin
      calc_state_reg <= C_IDLE;
      calc_ch_reg <= 3'h0;
      rms_valid <= 1'b0;
      for (k = 0; k < `SRA_NUM_CH; k = k + 1) begin
        rms_reg[k] <= {`SRA_RESULT_W{1'b0}};
      end
    end else begin
      rms_valid <= 1'b0;
      case (calc_state_reg)
        C_IDLE: begin
          if (acq_state_reg == A_SWAP) begin
            calc_ch_reg <= 3'h0;
            calc_state_reg <= C_START;
          end
        end
        C_START: begin
          calc_state_reg <= C_WAIT;
        end
        C_WAIT: begin
          if (root_done) begin
            rms_reg[calc_ch_reg] <= scaled - offset_reg[calc_ch_reg];
            if (calc_ch_reg == `SRA_LAST_CH) begin
              rms_valid <= 1'b1;
              calc_state_reg <= C_IDLE;
            end else begin
              calc_ch_reg <= calc_ch_reg + 3'h1;
              calc_state_reg <= C_START;
            end
          end
        end
        default: begin
          calc_state_reg <= C_IDLE;
        end
      endcase
    end
  end

endmodule // sra_rms_accum

// file: verification/sra_conv_model.sv
`timescale 1ns/1ps

// seven converters: one ready pulse per sample set
module sra_conv_model #(
  parameter GAP = 12
) (
  input wire core_clk,
  input wire reset_n,
  input wire send,
  input wire [167:0] set_data,
  output logic sample_ready,
  output logic [167:0] sample_data,
  output logic busy
);
  logic [167:0] hold;
  int cnt;
  always @(posedge core_clk) begin
    if (!reset_n) begin
      sample_ready <= 1'b0;
      sample_data <= 168'h0;
      busy <= 1'b0;
    end else begin
      sample_ready <= 1'b0;
      // stale data is not kept after capture
      if (sample_ready)
        sample_data <= ~sample_data;
      if (send) begin
        hold <= set_data;
        cnt <= GAP;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt == 0) begin
          sample_ready <= 1'b1;
          sample_data <= hold;
          busy <= 1'b0;
        end else begin
          cnt <= cnt - 1;
        end
      end
    end
  end
endmodule // sra_conv_model

// file: verification/sra_rms_accum_checker.sv
`timescale 1ns/1ps
`include "sra_consts.vh"

module sra_rms_accum_checker #(
  parameter TICK_CYCLES = 100
) (
  input wire core_clk,
  input wire reset_n,
  input wire frame_ack,
  input wire modulator_clock,
  input wire second_tick,
  input wire frame_ready,
  input wire rms_valid,
  input wire [`SRA_NUM_CH*`SRA_RESULT_W-1:0] current_rms_result
);
  int gap_cnt;
  int since_frame;
  logic had_tick;
  logic ready_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // cycles since last tick and since last frame flag rise
  always @(posedge core_clk) begin
    ready_q <= frame_ready;
    if (!reset_n) begin
      gap_cnt <= 0;
      had_tick <= 1'b0;
      since_frame <= 1000;
    end else begin
      gap_cnt <= second_tick ? 0 : gap_cnt + 1;
      had_tick <= had_tick | second_tick;
      if (frame_ready && !ready_q)
        since_frame <= 0;
      else if (since_frame < 1000)
        since_frame <= since_frame + 1;
    end
  end
  sequence s_mod_high;
    modulator_clock[*4];
  endsequence
  sequence s_mod_low;
    !modulator_clock[*4];
  endsequence
  chk_tick_single: assert property (second_tick |=> !second_tick) else $error("tick too long");
  chk_tick_period: assert property (second_tick && had_tick |-> gap_cnt == TICK_CYCLES - 1)
    else $error("tick period wrong");
  chk_ack_clears: assert property (frame_ready && frame_ack |=> !frame_ready) else $error("ack ignored");
  chk_ready_holds: assert property (frame_ready && !frame_ack |=> frame_ready) else $error("flag dropped");
  chk_valid_single: assert property (rms_valid |=> !rms_valid) else $error("valid too long");
  chk_valid_follows: assert property ($rose(frame_ready) |-> ##[1:600] rms_valid) else $error("no results");
  chk_valid_cause: assert property (rms_valid |-> since_frame < 600) else $error("stray valid");
  chk_held_stable: assert property (since_frame >= 600 |=> $stable(current_rms_result))
    else $error("results moved");
  chk_mod_high: assert property ($rose(modulator_clock) |-> s_mod_high ##2 !modulator_clock)
    else $error("mod high phase");
  chk_mod_low: assert property ($fell(modulator_clock) |-> s_mod_low ##2 modulator_clock)
    else $error("mod low phase");
endmodule // sra_rms_accum_checker

bind sra_rms_accum sra_rms_accum_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .frame_ack(frame_ack),
  .modulator_clock(modulator_clock),
  .second_tick(second_tick),
  .frame_ready(frame_ready),
  .rms_valid(rms_valid),
  .current_rms_result(current_rms_result)
);

// file: verification/sra_rms_accum_tb.sv
`timescale 1ns/1ps

module sra_rms_accum_tb;
  logic core_clk = 0, reset_n = 0, frame_ack = 0, cfg_write = 0, send = 0;
  logic [2:0] cfg_channel = 0;
  logic [15:0] cfg_scale = 0;
  logic [31:0] cfg_offset = 0, lf = 43;
  logic [167:0] set_data = 0, sample_data;
  logic sample_ready, busy, modulator_clock, second_tick, frame_ready, rms_valid;
  logic [223:0] res;
  logic [63:0] dc [7], acc [7], sc [7], of [7];
  int errors = 0, check_count = 0, n, mc = 0, m0;
  sra_conv_model #(.GAP(12)) conv (.core_clk(core_clk), .reset_n(reset_n), .send(send),
    .set_data(set_data), .sample_ready(sample_ready), .sample_data(sample_data), .busy(busy));
  sra_rms_accum #(.TICK_CYCLES(100), .FRAME_SHIFT(2)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .sample_ready(sample_ready), .sample_data(sample_data), .frame_ack(frame_ack), .cfg_write(cfg_write),
    .cfg_channel(cfg_channel), .cfg_scale(cfg_scale), .cfg_offset(cfg_offset),
    .modulator_clock(modulator_clock), .second_tick(second_tick), .frame_ready(frame_ready),
    .rms_valid(rms_valid), .current_rms_result(res));
  initial forever #50 core_clk = ~core_clk;
  always @(posedge modulator_clock) mc++;
  function logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function logic [63:0] isq(input logic [63:0] v);
    logic [63:0] r;
    r = 0;
    for (int b = 31; b >= 0; b--) begin
      if ((r | (64'h1 << b)) * (r | (64'h1 << b)) <= v)
        r = r | (64'h1 << b);
    end
    return r;
  endfunction
  task check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge core_clk);
    #1;
  endtask
  task cfg(input int c, input logic [31:0] r);
    step;
    cfg_write = 1;
    cfg_channel = c[2:0];
    cfg_scale = r[15:0];
    cfg_offset = {16'h0, r[31:16]};
    if (c < 7) begin
      sc[c] = r[15:0];
      of[c] = r[31:16];
    end
    step;
    cfg_write = 0;
  endtask
  // four sample sets fill one frame
  task frame;
    logic [63:0] x, e;
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 7; c++) begin
        x = 64'h40000 | (rnd() & 64'h3FFFF);
        set_data[24*c +: 24] = x[23:0];
        e = x - (dc[c] >> 16);
        acc[c] += e * e;
        // estimate moves by the corrected sample over 256, integer part used
        dc[c] += e << 8;
      end
      step;
      send = 1;
      step;
      send = 0;
      n = 0;
      while (busy === 1'b1 && n < 100) begin
        step;
        n++;
      end
    end
    n = 0;
    while (frame_ready !== 1'b1 && n < 50) begin
      step;
      n++;
    end
    check(frame_ready, 1);
    while (rms_valid !== 1'b1 && n < 700) begin
      step;
      n++;
    end
    check(rms_valid, 1);
    for (int c = 0; c < 7; c++) begin
      e = ((isq(acc[c] >> 2) * sc[c]) >> 14) - of[c];
      check(res[32*c +: 32], e[31:0]);
      acc[c] = 0;
    end
    step;
    frame_ack = 1;
    step;
    frame_ack = 0;
    check(frame_ready, 0);
    $display("frame test done");
  endtask
  task results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    for (int c = 0; c < 7; c++) begin
      dc[c] = 0;
      acc[c] = 0;
      sc[c] = 64'h4000;
      of[c] = 0;
    end
    repeat (6) @(posedge core_clk);
    #1 reset_n = 1;
    check(res === 224'h0, 1);
    frame;
    for (int c = 0; c < 8; c++) cfg(c, rnd());
    frame;
    frame;
    n = 0;
    m0 = mc;
    repeat (1000) begin
      step;
      if (second_tick === 1'b1)
        n++;
    end
    check(n, 10);
    check((mc - m0 == 104) || (mc - m0 == 105), 1);
    $display("clock test done");
    results;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    results;
  end
endmodule // sra_rms_accum_tb
